// file: hdl/crc16_serial.sv
/*
  Bit-serial 16-stage CRC register, reflected form, LSB-first data.
  Assumes the caller pulses init, feed or shift for one clock each.
*/
`timescale 1ns/1ns
module crc16_serial
  import sync_line_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // control
  input wire logic bit_mode,
  input wire logic init,
  input wire logic feed,
  input wire logic din,
  input wire logic shift,
  // state
  output logic [15:0] crc_r
);
  logic [15:0] base;
  logic [15:0] poly;
  logic [15:0] crc_nxt;

  always_comb
  begin
    base = init ? (bit_mode ? CCITT_PRESET : CRC16_PRESET) : crc_r;
    poly = bit_mode ? CCITT_POLY_REFL : CRC16_POLY_REFL;
    if (feed)
      crc_nxt = (base >> 1) ^ ((base[0] ^ din) ? poly : 16'h0000);
    else if (shift)
      crc_nxt = base >> 1;
    else
      crc_nxt = base;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      crc_r <= 16'h0000;
    else if (init || feed || shift)
      crc_r <= crc_nxt;
  end

  property p_crc_preset;
    @(posedge clock) disable iff (!rstn)
    (init && !feed && !shift) |=> (crc_r == ($past(bit_mode) ? CCITT_PRESET : CRC16_PRESET));
  endproperty
  a_crc_preset: assert property (p_crc_preset) else $error("crc preset wrong");

  property p_crc_step;
    @(posedge clock) disable iff (!rstn)
    (feed && !init && bit_mode) |=> (crc_r[15] == ($past(crc_r[0]) ^ $past(din)));
  endproperty
  a_crc_step: assert property (p_crc_step) else $error("ccitt step wrong");
endmodule : crc16_serial

// file: hdl/sync_line_pkg.sv
/*
  Shared constants for the synchronous line datapath: register map,
  field positions, reset values, CRC constants and state encodings.
  Assumes a 32-bit AHB-Lite register bus, one word per register.
*/
package sync_line_pkg;
  localparam int SILO_DEPTH = 64;

  // register byte offsets
  localparam logic [7:0] ADDR_TX_DATA = 8'h00;
  localparam logic [7:0] ADDR_RX_DATA = 8'h04;
  localparam logic [7:0] ADDR_RX_CTRL = 8'h08;
  localparam logic [7:0] ADDR_CTRL = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_SYNC = 8'h14;

  // transmit silo word: char in [7:0]
  localparam int TXW_START = 8;
  localparam int TXW_END = 9;
  // receive_control_register fields
  localparam int RXC_MATCH = 0;
  localparam int RXC_BLKEND = 1;
  localparam int RXC_READY = 4;
  localparam int RXC_ACTIVE = 6;
  // control register: 1 selects bit_oriented_mode
  localparam int CTRL_MODE = 0;
  // status register fields
  localparam int ST_TX_FULL = 0;
  localparam int ST_TX_EMPTY = 1;
  localparam int ST_RTS = 2;
  localparam int ST_TX_BUSY = 3;
  localparam int ST_RX_OVERRUN = 4;

  localparam logic CTRL_MODE_RESET = 1'b0;
  localparam logic [7:0] SYNC_RESET = 8'h96;
  localparam logic [7:0] FLAG_PATTERN = 8'h7e;
  localparam logic [1:0] BYTE_SYNC_NEED = 2'h2;
  localparam logic [1:0] BIT_FLAG_NEED = 2'h1;

  // reflected forms of x16+x15+x2+1 and x16+x12+x5+1
  localparam logic [15:0] CRC16_POLY_REFL = 16'ha001;
  localparam logic [15:0] CCITT_POLY_REFL = 16'h8408;
  localparam logic [15:0] CRC16_PRESET = 16'h0000;
  localparam logic [15:0] CCITT_PRESET = 16'hffff;
  // octal 016417, in normal bit order
  localparam logic [15:0] CCITT_GOOD_RESIDUE = 16'h1d0f;
  localparam logic [3:0] CHECK_BITS_LAST = 4'hf;
  localparam logic [2:0] CHAR_BITS_LAST = 3'h7;
  localparam logic [3:0] CRC_FEED_BITS = 4'h8;

  // link pin index in the synchroniser bank
  localparam int LNK_TXC = 0;
  localparam int LNK_RXC = 1;
  localparam int LNK_RXD = 2;
  localparam int LNK_CTS = 3;
  localparam int LNK_DSR = 4;
  localparam int LINK_W = 5;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_WAIT = 2'b01,
    TX_DATA = 2'b10,
    TX_CHECK = 2'b11
  } tx_state_e;

  typedef enum logic [1:0] {
    RX_HUNT = 2'b00,
    RX_ALIGN = 2'b01,
    RX_ACTIVE = 2'b10
  } rx_state_e;
endpackage : sync_line_pkg

// file: hdl/sync_line_silo_crc_datapath.sv
/*
  Synchronous line datapath: transmit silo, serialiser with automatic
  request-to-send and check word, receive deserialiser with sync/flag
  hunt, receive CRC check and receive silo, AHB-Lite register slave.
  Assumes a zero-wait AHB-Lite master and modem pins asynchronous to
  clock, with link clocks at least eight times slower than clock.
*/
// Functional notes
// - 64-deep transmit silo, written by software, never read back.
// - start and end markers travel in the silo with each character.
// - any character at silo output raises request-to-send automatically.
// - serialising starts only once clear-to-send and data-set-ready are true.
// - characters sent with the start marker are kept out of the CRC.
// - CRC covers first character without start marker and all later ones.
// - end marker makes the check word follow the last data character.
// - characters after an end marker start a fresh CRC.
// - 64-deep receive silo, filled by receiver, reads pop it.
// - activate after two syncs in byte mode, one flag in bit mode.
// - each received data character enters the silo unless it is full, then feeds the CRC.
// - receive control shows receiver active in bit 6, ready in bit 4.
// - ready shows again for every further character in the silo.
// - bit 0 of receive control is the check match flag.
// - bit mode sets block end in bit 1 together with a match.
// - both CRC registers have 16 stages, set up by mode.
// - bit mode uses generator x16 + x12 + x5 + 1.
// - byte mode uses generator x16 + x15 + x2 + 1.
// - byte mode clears CRC at message start, sends it unmodified.
// - byte mode match only on zero remainder; software samples at end.
// - bit mode presets transmit CRC to ones, sends it complemented.
// - bit mode presets receive CRC to ones, good remainder octal 016417.
// - bit mode uses flags with CCITT CRC, byte mode 8-bit with CRC-16.
// - serial line data is synchronous, least significant bit first.
`timescale 1ns/1ns
module sync_line_silo_crc_datapath
  import sync_line_pkg::*;
#(
  parameter int DEPTH = SILO_DEPTH
)
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // modem side
  input wire logic tx_clk_pin,
  input wire logic rx_clk_pin,
  input wire logic rxd_pin,
  input wire logic cts_pin,
  input wire logic dsr_pin,
  output logic txd,
  output logic rts
);
  import sync_line_pkg::*;
  localparam int AW = $clog2(DEPTH);

  // pin synchronisers and filtered levels
  logic [LINK_W-1:0] s1_r, s2_r, s3_r, lvl_r, lvl_d_r;
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      lvl_r <= '0;
      lvl_d_r <= '0;
    end
    else
    begin
      s1_r <= {dsr_pin, cts_pin, rxd_pin, rx_clk_pin, tx_clk_pin};
      s2_r <= s1_r;
      s3_r <= s2_r;
      // a change counts only once two stages agree
      lvl_r <= (s2_r & s3_r) | (lvl_r & (s2_r ^ s3_r));
      lvl_d_r <= lvl_r;
    end
  end
  logic tx_fall, rx_rise, modem_ok;
  assign tx_fall = lvl_d_r[LNK_TXC] & ~lvl_r[LNK_TXC];
  assign rx_rise = ~lvl_d_r[LNK_RXC] & lvl_r[LNK_RXC];
  assign modem_ok = lvl_r[LNK_CTS] & lvl_r[LNK_DSR];

  // bus slave, zero wait states
  logic ap_take, ap_hit, wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [31:0] rd_val;
  assign ap_take = hsel & hready & htrans[1];
  assign ap_hit = (haddr[31:8] == 24'h000000) && (hsize == 3'b010);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end
    else
    begin
      wr_pend_r <= ap_take & hwrite & ap_hit;
      wr_addr_r <= haddr[7:0];
    end
  end
  logic wr_tx, wr_rxc, wr_ctrl, wr_stat, wr_sync;
  assign wr_tx = wr_pend_r && wr_addr_r == ADDR_TX_DATA;
  assign wr_rxc = wr_pend_r && wr_addr_r == ADDR_RX_CTRL;
  assign wr_ctrl = wr_pend_r && wr_addr_r == ADDR_CTRL;
  assign wr_stat = wr_pend_r && wr_addr_r == ADDR_STATUS;
  assign wr_sync = wr_pend_r && wr_addr_r == ADDR_SYNC;

  logic mode_r;
  logic [7:0] sync_r;
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      mode_r <= CTRL_MODE_RESET;
      sync_r <= SYNC_RESET;
    end
    else
    begin
      if (wr_ctrl)
        mode_r <= hwdata[CTRL_MODE];
      if (wr_sync)
        sync_r <= hwdata[7:0];
    end
  end

  // transmit silo
  logic [9:0] tx_mem [DEPTH];
  logic [AW:0] tx_wp_r, tx_rp_r, tx_count;
  logic [9:0] head;
  logic tx_empty, tx_full, tx_pop;
  assign tx_count = tx_wp_r - tx_rp_r;
  assign tx_empty = tx_count == '0;
  assign tx_full = tx_count[AW];
  assign head = tx_mem[tx_rp_r[AW-1:0]];
  always_ff @(posedge clock)
  begin
    if (wr_tx && !tx_full)
      tx_mem[tx_wp_r[AW-1:0]] <= hwdata[9:0];
  end
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      tx_wp_r <= '0;
      tx_rp_r <= '0;
    end
    else
    begin
      // write-only; writes to a full silo are dropped
      if (wr_tx && !tx_full)
        tx_wp_r <= tx_wp_r + 1'b1;
      if (tx_pop)
        tx_rp_r <= tx_rp_r + 1'b1;
    end
  end

  // transmitter
  tx_state_e tx_state_r;
  logic [6:0] tx_sh_r;
  logic [3:0] tx_left_r;
  logic cur_start_r, cur_eom_r, fresh_r;
  logic need_char, tx_init, tx_feed, tx_din, tx_shift, chk_bit;
  logic [15:0] tx_crc;
  assign need_char = tx_fall && tx_left_r == 4'h0
    && ((tx_state_r == TX_DATA && !cur_eom_r) || tx_state_r == TX_CHECK);
  assign tx_pop = need_char & !tx_empty;
  // fresh CRC at message start and after every check word
  assign tx_init = tx_pop & (fresh_r | head[TXW_START]);
  assign tx_feed = (tx_pop & !head[TXW_START])
    | (tx_fall && tx_state_r == TX_DATA && tx_left_r != 4'h0 && !cur_start_r);
  assign tx_din = tx_pop ? head[0] : tx_sh_r[0];
  assign tx_shift = tx_fall && ((tx_state_r == TX_DATA && tx_left_r == 4'h0 && cur_eom_r)
    || (tx_state_r == TX_CHECK && tx_left_r != 4'h0));
  // complement in bit mode; unmodified in byte mode
  assign chk_bit = tx_crc[0] ^ mode_r;

  crc16_serial u_tx_crc (
    .clock(clock),
    .rstn(rstn),
    .bit_mode(mode_r),
    .init(tx_init),
    .feed(tx_feed),
    .din(tx_din),
    .shift(tx_shift),
    .crc_r(tx_crc)
  );

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      tx_state_r <= TX_IDLE;
      tx_sh_r <= 7'h00;
      tx_left_r <= 4'h0;
      cur_start_r <= 1'b0;
      cur_eom_r <= 1'b0;
      fresh_r <= 1'b1;
      txd <= 1'b1;
      rts <= 1'b0;
    end
    else if (tx_pop)
    begin
      tx_state_r <= TX_DATA;
      txd <= head[0];
      tx_sh_r <= head[7:1];
      tx_left_r <= {1'b0, CHAR_BITS_LAST};
      cur_start_r <= head[TXW_START];
      cur_eom_r <= head[TXW_END];
      fresh_r <= 1'b0;
    end
    else
    begin
      unique case (tx_state_r)
        TX_IDLE:
        begin
          // request-to-send raised by silo contents alone
          if (!tx_empty)
          begin
            tx_state_r <= TX_WAIT;
            rts <= 1'b1;
          end
        end
        TX_WAIT:
        begin
          if (modem_ok)
          begin
            tx_state_r <= TX_DATA;
            tx_left_r <= 4'h0;
            cur_eom_r <= 1'b0;
            fresh_r <= 1'b1;
          end
        end
        TX_DATA:
        begin
          if (tx_fall)
          begin
            if (tx_left_r != 4'h0)
            begin
              txd <= tx_sh_r[0];
              tx_sh_r <= tx_sh_r >> 1;
              tx_left_r <= tx_left_r - 4'h1;
            end
            else if (cur_eom_r)
            begin
              tx_state_r <= TX_CHECK;
              txd <= chk_bit;
              tx_left_r <= CHECK_BITS_LAST;
              fresh_r <= 1'b1;
            end
            else
              // underrun: idle mark while waiting for more data
              txd <= 1'b1;
          end
        end
        TX_CHECK:
        begin
          if (tx_fall)
          begin
            if (tx_left_r != 4'h0)
            begin
              txd <= chk_bit;
              tx_left_r <= tx_left_r - 4'h1;
            end
            else
            begin
              tx_state_r <= TX_IDLE;
              txd <= 1'b1;
              rts <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  // receiver
  rx_state_e rx_state_r;
  logic [7:0] win_r, win_nxt, pattern;
  logic [2:0] bitc_r;
  logic [1:0] nsync_r, need;
  logic rx_got, rx_close, byte_end;
  assign win_nxt = {lvl_r[LNK_RXD], win_r[7:1]};
  assign pattern = mode_r ? FLAG_PATTERN : sync_r;
  assign need = mode_r ? BIT_FLAG_NEED : BYTE_SYNC_NEED;
  assign byte_end = rx_rise && bitc_r == CHAR_BITS_LAST;
  assign rx_got = byte_end
    && ((rx_state_r == RX_ALIGN && win_nxt != pattern && nsync_r >= need)
    || (rx_state_r == RX_ACTIVE && !(mode_r && win_nxt == FLAG_PATTERN)));
  assign rx_close = byte_end && rx_state_r == RX_ACTIVE && mode_r && win_nxt == FLAG_PATTERN;

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rx_state_r <= RX_HUNT;
      win_r <= 8'h00;
      bitc_r <= 3'h0;
      nsync_r <= 2'h0;
    end
    else if (wr_rxc)
      // software write restarts the hunt
      rx_state_r <= RX_HUNT;
    else if (rx_rise)
    begin
      win_r <= win_nxt;
      bitc_r <= bitc_r + 3'h1;
      unique case (rx_state_r)
        RX_HUNT:
        begin
          if (win_nxt == pattern)
          begin
            rx_state_r <= RX_ALIGN;
            nsync_r <= 2'h1;
            bitc_r <= 3'h0;
          end
        end
        RX_ALIGN:
        begin
          if (byte_end)
          begin
            if (win_nxt == pattern)
              nsync_r <= (nsync_r == 2'h3) ? nsync_r : nsync_r + 2'h1;
            else if (nsync_r >= need)
              rx_state_r <= RX_ACTIVE;
            else
              rx_state_r <= RX_HUNT;
          end
        end
        RX_ACTIVE:
        begin
          if (rx_close)
          begin
            rx_state_r <= RX_ALIGN;
            nsync_r <= 2'h1;
          end
        end
        default: rx_state_r <= RX_HUNT;
      endcase
    end
  end

  // byte-wide CRC feed, one bit per clock after each character
  logic [7:0] cf_sh_r;
  logic [3:0] cf_left_r;
  logic cf_first_r, cf_done_r, rx_feed;
  logic [15:0] rx_crc, rx_crc_rev;
  assign rx_feed = cf_left_r != 4'h0;
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      cf_sh_r <= 8'h00;
      cf_left_r <= 4'h0;
      cf_first_r <= 1'b0;
      cf_done_r <= 1'b0;
    end
    else
    begin
      cf_done_r <= cf_left_r == 4'h1;
      if (rx_got)
      begin
        cf_sh_r <= win_nxt;
        cf_left_r <= CRC_FEED_BITS;
        cf_first_r <= rx_state_r == RX_ALIGN;
      end
      else if (rx_feed)
      begin
        cf_sh_r <= cf_sh_r >> 1;
        cf_left_r <= cf_left_r - 4'h1;
        cf_first_r <= 1'b0;
      end
    end
  end

  // receive CRC preset by mode at first character
  crc16_serial u_rx_crc (
    .clock(clock),
    .rstn(rstn),
    .bit_mode(mode_r),
    .init(rx_feed & cf_first_r),
    .feed(rx_feed),
    .din(cf_sh_r[0]),
    .shift(1'b0),
    .crc_r(rx_crc)
  );
  assign rx_crc_rev = {<<{rx_crc}};

  // receive silo
  logic [7:0] rx_mem [DEPTH];
  logic [AW:0] rx_wp_r, rx_rp_r, rx_count;
  logic rx_full, rx_pop, rx_push;
  assign rx_count = rx_wp_r - rx_rp_r;
  assign rx_full = rx_count[AW];
  assign rx_push = rx_got & !rx_full;
  // each read of the data register advances a non-empty silo
  assign rx_pop = ap_take && !hwrite && ap_hit && haddr[7:0] == ADDR_RX_DATA
    && rx_count != '0;
  always_ff @(posedge clock)
  begin
    if (rx_push)
      rx_mem[rx_wp_r[AW-1:0]] <= win_nxt;
  end

  logic match_r, blkend_r, overrun_r;
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rx_wp_r <= '0;
      rx_rp_r <= '0;
      match_r <= 1'b0;
      blkend_r <= 1'b0;
      overrun_r <= 1'b0;
    end
    else
    begin
      if (rx_push)
        rx_wp_r <= rx_wp_r + 1'b1;
      if (rx_pop)
        rx_rp_r <= rx_rp_r + 1'b1;
      if (wr_rxc)
        match_r <= 1'b0;
      else if (cf_done_r)
        match_r <= mode_r ? (rx_crc_rev == CCITT_GOOD_RESIDUE) : (rx_crc == CRC16_PRESET);
      if (rx_close)
        blkend_r <= match_r;
      else if (wr_rxc || (rx_got && rx_state_r == RX_ALIGN))
        blkend_r <= 1'b0;
      // set wins over a write-one clear
      if (rx_got && rx_full)
        overrun_r <= 1'b1;
      else if (wr_stat && hwdata[ST_RX_OVERRUN])
        overrun_r <= 1'b0;
    end
  end

  // read mux, registered into the data phase
  always_comb
  begin
    rd_val = 32'h00000000;
    unique case (haddr[7:0])
      ADDR_RX_DATA: rd_val[7:0] = rx_mem[rx_rp_r[AW-1:0]];
      ADDR_RX_CTRL:
      begin
        rd_val[RXC_ACTIVE] = rx_state_r == RX_ACTIVE;
        rd_val[RXC_READY] = rx_count != '0;
        rd_val[RXC_BLKEND] = blkend_r;
        rd_val[RXC_MATCH] = match_r;
      end
      ADDR_CTRL: rd_val[CTRL_MODE] = mode_r;
      ADDR_STATUS:
      begin
        rd_val[ST_TX_FULL] = tx_full;
        rd_val[ST_TX_EMPTY] = tx_empty;
        rd_val[ST_RTS] = rts;
        rd_val[ST_TX_BUSY] = tx_state_r != TX_IDLE;
        rd_val[ST_RX_OVERRUN] = overrun_r;
      end
      ADDR_SYNC: rd_val[7:0] = sync_r;
      default: rd_val = 32'h00000000;
    endcase
    if (!ap_hit)
      rd_val = 32'h00000000;
  end
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      hrdata <= 32'h00000000;
    else if (ap_take && !hwrite)
      hrdata <= rd_val;
  end

  property p_tx_depth;
    @(posedge clock) disable iff (!rstn)
    (wr_tx && tx_full && !tx_pop) |=> (tx_count == $past(tx_count));
  endproperty
  a_tx_depth: assert property (p_tx_depth) else $error("full silo accepted a write");

  property p_rts_auto;
    @(posedge clock) disable iff (!rstn)
    (tx_state_r == TX_IDLE && !tx_empty) |=> (rts && tx_state_r == TX_WAIT);
  endproperty
  a_rts_auto: assert property (p_rts_auto) else $error("rts not raised");

  property p_modem_gate;
    @(posedge clock) disable iff (!rstn)
    (tx_state_r == TX_WAIT ##1 tx_state_r == TX_DATA) |-> $past(modem_ok);
  endproperty
  a_modem_gate: assert property (p_modem_gate) else $error("sent without cts/dsr");

  property p_start_excluded;
    @(posedge clock) disable iff (!rstn)
    (tx_fall && tx_state_r == TX_DATA && cur_start_r && !tx_pop) |-> !tx_feed;
  endproperty
  a_start_excluded: assert property (p_start_excluded) else $error("start char in crc");

  property p_check_after_eom;
    @(posedge clock) disable iff (!rstn)
    $rose(tx_state_r == TX_CHECK) |-> $past(cur_eom_r) && $past(tx_left_r) == 4'h0;
  endproperty
  a_check_after_eom: assert property (p_check_after_eom) else $error("check word misplaced");

  property p_check_bit;
    @(posedge clock) disable iff (!rstn)
    (tx_fall && tx_state_r == TX_CHECK && tx_left_r != 4'h0)
      |=> txd == ($past(tx_crc[0]) ^ $past(mode_r));
  endproperty
  a_check_bit: assert property (p_check_bit) else $error("check bit polarity");

  property p_rx_pop;
    @(posedge clock) disable iff (!rstn)
    (rx_pop && !rx_push) |=> rx_count == $past(rx_count) - 1'b1;
  endproperty
  a_rx_pop: assert property (p_rx_pop) else $error("read did not advance silo");

  property p_byte_match;
    @(posedge clock) disable iff (!rstn)
    (cf_done_r && !mode_r && !wr_rxc) |=> match_r == ($past(rx_crc) == 16'h0000);
  endproperty
  a_byte_match: assert property (p_byte_match) else $error("byte mode match wrong");

  property p_active_syncs;
    @(posedge clock) disable iff (!rstn)
    (rx_got && rx_state_r == RX_ALIGN) |-> nsync_r >= (mode_r ? 2'h1 : 2'h2);
  endproperty
  a_active_syncs: assert property (p_active_syncs) else $error("active too early");
endmodule : sync_line_silo_crc_datapath

// file: tb/line_modem_model.sv
/*
  Synchronous modem model for the line unit bench.
  Assumes link clocks of 160 ns, far slower than the unit clock.
*/
`timescale 1ns/1ns
module line_modem_model
(
  // toward the line unit
  output logic tx_clk_pin,
  output logic rx_clk_pin,
  output logic rxd_pin,
  output logic cts_pin,
  output logic dsr_pin,
  // from the line unit
  input wire logic txd,
  input wire logic rts
);
  logic tx_bits[$];
  // set by the bench to keep clear-to-send low
  logic hold_cts = 1'b0;
  initial
  begin
    tx_clk_pin = 1'b0;
    rx_clk_pin = 1'b0;
    rxd_pin = 1'b1;
    cts_pin = 1'b0;
    dsr_pin = 1'b0;
  end
  always @(rts)
  begin
    cts_pin <= #500 rts && !hold_cts;
    dsr_pin <= #300 rts;
  end
  // clock stands still without request or clear-to-send
  always #80 tx_clk_pin = (rts || cts_pin) ? ~tx_clk_pin : 1'b0;
  always @(posedge tx_clk_pin)
    if (cts_pin)
      tx_bits.push_back(txd);
  // lsb first, one bit per clock
  task automatic send_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++)
    begin
      rxd_pin = b[i];
      #80 rx_clk_pin = 1'b1;
      #80 rx_clk_pin = 1'b0;
    end
    rxd_pin = ~b[7];
  endtask : send_byte
endmodule : line_modem_model

// file: tb/sync_line_silo_crc_datapath_bench.sv
/*
  Self-checking bench for the line unit: AHB-Lite register tasks,
  receive and transmit in both modes, transmit silo filled to full.
  Assumes the modem model drives the link pins.
*/
`timescale 1ns/1ns
module sync_line_silo_crc_datapath_bench;
  import sync_line_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, txd, rts;
  logic [31:0] hrdata;
  logic tx_clk_pin, rx_clk_pin, rxd_pin, cts_pin, dsr_pin;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic bm;
  logic [15:0] crc;
  logic [7:0] got, exp_q[$];

  always #5 clock = ~clock;

  sync_line_silo_crc_datapath dut_u (.clock(clock), .rstn(rstn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .tx_clk_pin(tx_clk_pin), .rx_clk_pin(rx_clk_pin), .rxd_pin(rxd_pin),
    .cts_pin(cts_pin), .dsr_pin(dsr_pin), .txd(txd), .rts(rts));

  line_modem_model modem_u (.tx_clk_pin(tx_clk_pin), .rx_clk_pin(rx_clk_pin),
    .rxd_pin(rxd_pin), .cts_pin(cts_pin), .dsr_pin(dsr_pin), .txd(txd), .rts(rts));

  task automatic complete_run();
    if (miscompares == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run

  task automatic check(input string name, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, e, s);
    end
  endtask : check

  // address phase held until hready, then data phase until hready
  task automatic bus_cycle(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    check("hresp", 32'h0, {31'h0, hresp});
  endtask : bus_cycle

  task automatic bus_read(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    bus_cycle(a, 1'b0, 32'h0);
    check("hrdata", e, hrdata & m);
  endtask : bus_read

  task automatic wait_rts(input logic v);
    for (int n = 0; n < 4000 && rts !== v; n++) @(posedge clock);
    check("rts", {31'h0, v}, {31'h0, rts});
  endtask : wait_rts

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b,
                                           input logic m);
    logic fb;
    for (int i = 0; i < 8; i++)
    begin
      fb = c[0] ^ b[i];
      c = c >> 1;
      if (fb) c = c ^ (m ? CCITT_POLY_REFL : CRC16_POLY_REFL);
    end
    return c;
  endfunction : crc_step

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      miscompares++;
      complete_run();
    end
  end

  initial
  begin
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    bus_read(ADDR_RX_CTRL, 32'h0, 32'hffffffff);
    bus_read(ADDR_SYNC, 32'h96, 32'hffffffff);
    bus_read(ADDR_STATUS, 32'h2, 32'hffffffff);
    bus_read(8'h20, 32'h0, 32'hffffffff);
    for (int m = 0; m < 2; m++)
    begin
      bm = m[0];
      bus_cycle(ADDR_CTRL, 1'b1, {31'h0, bm});
      // sync char moved off its reset value
      bus_cycle(ADDR_SYNC, 1'b1, 32'h16);
      bus_cycle(ADDR_RX_CTRL, 1'b1, 32'h0);
      crc = crc_step(crc_step(bm ? CCITT_PRESET : CRC16_PRESET, 8'h41, bm), 8'h42, bm);
      if (bm) crc = ~crc;
      exp_q = '{8'h41, 8'h42, crc[7:0], crc[15:8]};
      repeat (bm ? 1 : 2) modem_u.send_byte(bm ? FLAG_PATTERN : 8'h16);
      foreach (exp_q[i]) modem_u.send_byte(exp_q[i]);
      if (bm) modem_u.send_byte(FLAG_PATTERN);
      repeat (40) @(posedge clock);
      bus_read(ADDR_RX_CTRL, bm ? 32'h13 : 32'h51, bm ? 32'h13 : 32'h51);
      foreach (exp_q[i]) bus_read(ADDR_RX_DATA, exp_q[i], 32'hff);
      bus_read(ADDR_RX_CTRL, 32'h0, 32'h10);
    end
    for (int m = 0; m < 2; m++)
    begin
      bm = m[0];
      bus_cycle(ADDR_CTRL, 1'b1, {31'h0, bm});
      bus_cycle(ADDR_TX_DATA, 1'b1, 32'h196);
      bus_cycle(ADDR_TX_DATA, 1'b1, 32'h41);
      bus_cycle(ADDR_TX_DATA, 1'b1, 32'h242);
      wait_rts(1'b1);
      wait_rts(1'b0);
      crc = crc_step(crc_step(bm ? CCITT_PRESET : CRC16_PRESET, 8'h41, bm), 8'h42, bm);
      if (bm) crc = ~crc;
      exp_q = '{8'h96, 8'h41, 8'h42, crc[7:0], crc[15:8]};
      // idle marks come before the first character
      while (modem_u.tx_bits.size() > 0 && modem_u.tx_bits[0] === 1'b1)
        void'(modem_u.tx_bits.pop_front());
      foreach (exp_q[i])
      begin
        for (int b = 0; b < 8; b++)
          got[b] = modem_u.tx_bits.size() > 0 ? modem_u.tx_bits.pop_front() : 1'bx;
        check("txd byte", exp_q[i], got);
      end
      // clear-to-send must fall before the next request
      repeat (100) @(posedge clock);
    end
    // clear-to-send withheld, so nothing leaves the silo
    modem_u.hold_cts = 1'b1;
    for (int i = 0; i < 65; i++)
      bus_cycle(ADDR_TX_DATA, 1'b1, 32'h55);
    bus_read(ADDR_STATUS, 32'hd, 32'hf);
    complete_run();
  end
endmodule : sync_line_silo_crc_datapath_bench
